// ==== bench/asc_remote.sv ====
// Remote serial station model on the receive and transmit lines
`timescale 1ns/1ns
`default_nettype none
module asc_remote #(
    parameter int BT = 16
) (
    input wire logic clk,
    output logic rxd,
    input wire logic txd
);
    // Line idles high
    initial rxd = 1'b1;
    // Send n bits LSB first, then release to idle
    task automatic send(input logic [11:0] f, input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (BT) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask : send
    // Capture n bits at mid-bit after a falling edge
    task automatic catch_frame(input int n, output logic [11:0] f);
        f = 12'h000;
        while (txd !== 1'b0) @(negedge clk);
        repeat (BT / 2) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            f[i] = txd;
            repeat (BT) @(negedge clk);
        end
    endtask : catch_frame
endmodule : asc_remote
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench of the serial channel
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic cts_n = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, rxd, txd, e;
    logic [31:0] r;
    logic [11:0] f;
    int miscompares = 0;
    int n_compared = 0;
    int lo;
    // 25 MHz clock
    always #20 clk = ~clk;
    asc_channel i_asc_channel (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd(rxd), .cts_n(cts_n), .txd(txd));
    asc_remote i_asc_remote (.clk(clk), .rxd(rxd), .txd(txd));
    ////////////////////////////////////////////////////////////
    // One APB transfer, result in r and e
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Compare one value
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, g, x);
        end
    endtask : chk
    // Count cycles with the line not idle
    task automatic quiet(input int n);
        lo = 0;
        repeat (n) begin
            @(negedge clk);
            if (txd !== 1'b1) lo++;
        end
    endtask : quiet
    // Verdict and end of run
    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        apb(0, 8'h08, 0);
        chk(r, 32'h00001311);
        apb(0, 8'h18, 0);
        chk(r & 32'h1, 32'h0);
        apb(0, 8'h40, 0);
        chk({31'h0, e}, 32'h1);
        apb(1, 8'h14, 32'h7ff);
        $display("Test reset done");
        apb(1, 8'h00, 32'h1f);
        i_asc_remote.send({3'b111, 8'ha4, 1'b0}, 11);
        apb(0, 8'h1c, 0);
        chk(r, 32'h800001a4);
        apb(1, 8'h00, 32'h31f);
        i_asc_remote.send({3'b101, 8'ha4, 1'b0}, 11);
        apb(0, 8'h1c, 0);
        chk(r, 32'h800002a4);
        apb(0, 8'h10, 0);
        chk(r & 32'h2, 32'h2);
        apb(1, 8'h10, 32'h7ff);
        i_asc_remote.send(12'h000, 12);
        repeat (40) @(posedge clk);
        apb(0, 8'h10, 0);
        chk(r & 32'h18, 32'h18);
        apb(0, 8'h1c, 0);
        chk(r & 32'h80000000, 32'h0);
        $display("Test receive done");
        apb(1, 8'h00, 32'h180f);
        apb(1, 8'h10, 32'h7ff);
        i_asc_remote.send({3'b111, 8'h13, 1'b0}, 10);
        apb(0, 8'h18, 0);
        chk(r & 32'h1, 32'h1);
        apb(0, 8'h10, 0);
        chk(r & 32'h40, 32'h40);
        apb(1, 8'h20, 32'h41);
        quiet(200);
        chk(lo, 0);
        fork
            i_asc_remote.send({3'b111, 8'h11, 1'b0}, 10);
            i_asc_remote.catch_frame(10, f);
        join
        chk({20'h0, f}, 32'h282);
        apb(0, 8'h18, 0);
        chk(r & 32'h1, 32'h0);
        apb(0, 8'h1c, 0);
        chk(r & 32'h80000000, 32'h0);
        $display("Test flow done");
        apb(1, 8'h00, 32'hd3);
        apb(1, 8'h10, 32'h7ff);
        apb(1, 8'h20, 32'h15);
        i_asc_remote.catch_frame(9, f);
        chk({20'h0, f}, 32'h1ea);
        repeat (48) @(posedge clk);
        apb(0, 8'h10, 0);
        chk(r & 32'h80, 32'h80);
        chk({31'h0, txd}, 32'h1);
        cts_n <= 1'b1;
        apb(1, 8'h20, 32'h3c);
        quiet(100);
        chk(lo, 0);
        @(posedge clk);
        cts_n <= 1'b0;
        i_asc_remote.catch_frame(9, f);
        chk({20'h0, f}, 32'h1f8);
        apb(1, 8'h00, 32'h20d3);
        repeat (3) @(negedge clk);
        chk({31'h0, txd}, 32'h0);
        apb(1, 8'h00, 32'hd3);
        repeat (3) @(negedge clk);
        chk({31'h0, txd}, 32'h1);
        $display("Test transmit done");
        apb(1, 8'h04, 32'hf);
        apb(1, 8'h0c, 32'h0004015a);
        apb(1, 8'h00, 32'h440d);
        apb(1, 8'h10, 32'h7ff);
        i_asc_remote.send({3'b111, 8'h5a, 1'b0}, 10);
        repeat (120) @(posedge clk);
        apb(0, 8'h10, 0);
        chk(r & 32'h301, 32'h301);
        apb(0, 8'h1c, 0);
        chk(r, 32'h8000005a);
        $display("Test isochronous done");
        final_report();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("[FAIL] %0t ns: timeout", $time);
        final_report();
    end
endmodule : testbench
`default_nettype wire

// ==== rtl/asc_channel.sv ====
// Asynchronous serial channel: APB registers, receiver, transmitter, flow control
`timescale 1ns/1ns
`default_nettype none
// Contract
// - One start bit, one or two stops
// - Character length five to eight bits
// - Optional parity: even, odd, mark, space
// - Sixteen-times receive clock, resync each start
// - Three samples, majority, every bit
// - Isochronous: asynchronous format, single sample
// - Receive LSB first while receiver enabled
// - Check framing, parity; flag; optionally store
// - Parity storage can be disabled
// - Threshold, format, termination character control queue
// - Optional idle time-out after last character
// - All-sent event, then idle ones
// - Break command forces line low
// - Detect all-zero break, drop it, flag
// - Break holds until one, then flag
// - Compare flow characters over character length
// - Mask ones skip compare; masks reset zero
// - Flow character needs framing, match, parity
// - Discard bit drops flow characters
// - Flow events; pause stops, resume restarts
// - Flow enable resets zero, forces resumed
// - Transmit only with clear-to-send low, resumed
`include "asc_params.svh"

module asc_channel
    import asc_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    input wire logic cts_n,
    output logic txd
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode
    logic [14:0] ctrl_q;
    logic [15:0] div_q;
    logic [31:0] flow_q;
    logic [31:0] rxcfg_q;
    logic [`ASC_NEVT-1:0] evt_q;
    logic [`ASC_NEVT-1:0] even_q;
    logic [`ASC_NEVT-1:0] evt_set;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic acc;
    logic wr;
    logic rx_en, ovs, par_en, stop2, parity_storage_disable, rx_fifo_data_format, termination_detect_enable, discard_flow_chars, inband_flow_enable, send_break_cmd, to_en;
    logic [1:0] char_length_field;
    asc_par_t par_mode;

    assign rx_en = ctrl_q[`ASC_C_RXEN];
    assign ovs = ctrl_q[`ASC_C_OVS];
    assign char_length_field = ctrl_q[`ASC_C_CHL];
    assign par_en = ctrl_q[`ASC_C_PAREN];
    assign par_mode = asc_par_t'(ctrl_q[`ASC_C_PARM]);
    assign stop2 = ctrl_q[`ASC_C_STOP2];
    assign parity_storage_disable = ctrl_q[`ASC_C_DPS];
    assign rx_fifo_data_format = ctrl_q[`ASC_C_RX_FIFO_DATA_FORMAT];
    assign termination_detect_enable = ctrl_q[`ASC_C_TERMINATION_DETECT_ENABLE];
    assign discard_flow_chars = ctrl_q[`ASC_C_DXS];
    assign inband_flow_enable = ctrl_q[`ASC_C_INBAND_FLOW_ENABLE];
    assign send_break_cmd = ctrl_q[`ASC_C_SEND_BREAK_CMD];
    assign to_en = ctrl_q[`ASC_C_TOEN];
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;

    // Receive queue, transmitter and flow state
    logic [AW-1:0] q_wp_q, q_rp_q;
    logic [AW:0] q_cnt_q;
    logic q_wr, q_rd, q_full, q_empty;
    asc_rxe_t q_wdata, q_rdata;
    asc_tx_st_t tx_state_q;
    logic [7:0] hold_q;
    logic hold_v_q;
    logic paused_q;
    logic line_q;
    asc_rx_st_t rx_state_q;

    assign q_full = q_cnt_q == (AW+1)'(DEPTH);
    assign q_empty = q_cnt_q == '0;
    assign q_rd = acc & !pwrite & (paddr == `ASC_OFF_RXD) & !q_empty;

    // APB: one wait cycle, answer registered
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & !pready;
            pslverr <= psel & penable & !pready & !rd_hit;
            if (psel && penable && !pready) begin
                prdata <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Read multiplexer and address decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `ASC_OFF_CTRL: rd_mux = {17'h0, ctrl_q};
            `ASC_OFF_DIV: rd_mux = {16'h0, div_q};
            `ASC_OFF_FLOW: rd_mux = flow_q;
            `ASC_OFF_RXCFG: rd_mux = rxcfg_q;
            `ASC_OFF_EVT: rd_mux = {21'h0, evt_q};
            `ASC_OFF_EVEN: rd_mux = {21'h0, even_q};
            `ASC_OFF_STAT: rd_mux = {16'h0, 8'(q_cnt_q), 4'h0, rx_state_q == RX_BRK,
                                     tx_state_q != TX_IDLE, hold_v_q, paused_q};
            `ASC_OFF_RXD: rd_mux = {!q_empty, 20'h0, q_rdata};
            `ASC_OFF_TXD: rd_mux = 32'h0000_0000;
            default: rd_hit = 1'b0;
        endcase
    end

    // Configuration registers; flow masks reset to zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_q <= `ASC_CTRL_RST;
            div_q <= `ASC_DIV_RST;
            flow_q <= `ASC_FLOW_RST;
            rxcfg_q <= `ASC_RXCFG_RST;
            even_q <= '0;
        end else if (wr) begin
            case (paddr)
                `ASC_OFF_CTRL: ctrl_q <= pwdata[14:0];
                `ASC_OFF_DIV: div_q <= pwdata[15:0];
                `ASC_OFF_FLOW: flow_q <= pwdata;
                `ASC_OFF_RXCFG: rxcfg_q <= pwdata;
                `ASC_OFF_EVEN: even_q <= pwdata[`ASC_NEVT-1:0];
                default: ;
            endcase
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            evt_q <= '0;
        end else begin
            evt_q <= (evt_q & ~((wr && paddr == `ASC_OFF_EVT) ? pwdata[`ASC_NEVT-1:0] : '0)) | (evt_set & even_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit-clock enable
    logic [15:0] div_cnt_q;
    logic tick;

    assign tick = div_cnt_q == div_q;

    // Divider giving one tick per sixteenth bit or per bit
    always_ff @(posedge clk) begin
        if (!nrst || tick) begin
            div_cnt_q <= 16'h0000;
        end else begin
            div_cnt_q <= div_cnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver
    logic [3:0] os_cnt_q;
    logic [1:0] smp_q;
    logic [2:0] bit_idx_q;
    logic [7:0] shf_q;
    logic rpar_q, fe_q, allz_q, sidx_q;
    logic dec, bitv, last_data, last_stop, is_brk, fin;
    logic done_q;
    asc_rxe_t rxc_q;

    assign dec = tick & (!ovs | (os_cnt_q == `ASC_OS_DEC));
    assign bitv = ovs ? ((smp_q[1] & smp_q[0]) | (smp_q[1] & rxd) | (smp_q[0] & rxd)) : rxd;
    assign last_data = bit_idx_q == ({1'b0, char_length_field} + 3'd4);
    assign last_stop = !stop2 | sidx_q;
    assign is_brk = (shf_q == 8'h00) & !(par_en & rpar_q) & allz_q & !bitv;
    assign fin = (rx_state_q == RX_STOP) & dec & last_stop;

    // Oversample phase, restarted on each start edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            os_cnt_q <= 4'h0;
        end else if (tick) begin
            os_cnt_q <= (rx_state_q == RX_IDLE) ? {3'h0, !rxd} : os_cnt_q + 4'h1;
        end
    end

    // First two of three samples around bit centre
    always_ff @(posedge clk) begin
        if (!nrst) begin
            smp_q <= 2'b11;
        end else if (tick && (os_cnt_q == `ASC_OS_S0 || os_cnt_q == `ASC_OS_S1)) begin
            smp_q <= {smp_q[0], rxd};
        end
    end

    // Receive framing state machine
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_state_q <= RX_IDLE;
            bit_idx_q <= 3'd0;
            shf_q <= 8'h00;
            rpar_q <= 1'b0;
            fe_q <= 1'b0;
            allz_q <= 1'b1;
            sidx_q <= 1'b0;
        end else begin
            case (rx_state_q)
                RX_IDLE: begin
                    if (tick && !rxd) begin
                        rx_state_q <= ovs ? RX_START : RX_DATA;
                        bit_idx_q <= 3'd0;
                        shf_q <= 8'h00;
                        rpar_q <= 1'b0;
                        fe_q <= 1'b0;
                        allz_q <= 1'b1;
                        sidx_q <= 1'b0;
                    end
                end
                RX_START: begin
                    if (dec) begin
                        rx_state_q <= bitv ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (dec) begin
                        shf_q[bit_idx_q] <= bitv;
                        bit_idx_q <= bit_idx_q + 3'd1;
                        if (last_data) begin
                            rx_state_q <= par_en ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (dec) begin
                        rpar_q <= bitv;
                        rx_state_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (dec) begin
                        fe_q <= fe_q | !bitv;
                        allz_q <= allz_q & !bitv;
                        sidx_q <= 1'b1;
                        if (last_stop) begin
                            rx_state_q <= is_brk ? RX_BRK : RX_IDLE;
                        end
                    end
                end
                RX_BRK: begin
                    if (tick && rxd) begin
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // Completed character with its checks
    always_ff @(posedge clk) begin
        if (!nrst) begin
            done_q <= 1'b0;
            rxc_q <= '0;
        end else begin
            done_q <= fin & !is_brk;
            if (fin) begin
                rxc_q.data <= shf_q;
                rxc_q.par <= rpar_q;
                rxc_q.fe <= fe_q | !bitv;
                rxc_q.pe <= par_en & (rpar_q != asc_par_bit(shf_q, char_length_field, par_mode));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flow characters, queue fill and receive events
    logic flow_ok, is_res, is_pau, keep, thr_p, to_p, all_sent_irq_p;
    logic [15:0] to_cnt_q;
    logic to_arm_q;

    assign flow_ok = done_q & !rxc_q.fe & !rxc_q.pe;
    assign is_res = flow_ok & asc_match(rxc_q.data, flow_q[7:0], flow_q[23:16], char_length_field);
    assign is_pau = flow_ok & asc_match(rxc_q.data, flow_q[15:8], flow_q[31:24], char_length_field);
    assign keep = done_q & rx_en & !((is_res | is_pau) & discard_flow_chars);
    assign q_wr = keep & !q_full;
    assign thr_p = (rxcfg_q[11:8] != 4'h0) & (q_cnt_q >= (AW+1)'(rxcfg_q[11:8]));
    assign q_wdata = {rx_fifo_data_format & rxc_q.pe,
                      rx_fifo_data_format & rxc_q.fe,
                      !parity_storage_disable & par_en & rxc_q.par,
                      rxc_q.data & asc_len_mask(char_length_field)};
    assign evt_set = {keep & q_full,
                      done_q & termination_detect_enable & asc_match(rxc_q.data, rxcfg_q[7:0], 8'h00, char_length_field),
                      to_p, all_sent_irq_p, is_pau, is_res,
                      (rx_state_q == RX_BRK) & tick & rxd,
                      fin & is_brk,
                      done_q & rxc_q.pe, done_q & rxc_q.fe, thr_p};

    // Queue pointers and fill level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q_wp_q <= '0;
            q_rp_q <= '0;
            q_cnt_q <= '0;
        end else begin
            if (q_wr) begin
                q_wp_q <= q_wp_q + AW'(1);
            end
            if (q_rd) begin
                q_rp_q <= q_rp_q + AW'(1);
            end
            q_cnt_q <= q_cnt_q + (AW+1)'(q_wr) - (AW+1)'(q_rd);
        end
    end

    // Receive queue storage
    asc_rxq_mem #(.W($bits(asc_rxe_t)), .DEPTH(DEPTH), .AW(AW)) u_rxq (
        .clk(clk),
        .nrst(nrst),
        .we(q_wr),
        .waddr(q_wp_q),
        .wdata(q_wdata),
        .raddr(q_rp_q),
        .rdata(q_rdata)
    );

    assign to_p = to_en & to_arm_q & tick & (to_cnt_q == rxcfg_q[31:16]);

    // Idle time-out in ticks since the last character
    always_ff @(posedge clk) begin
        if (!nrst) begin
            to_cnt_q <= 16'h0000;
            to_arm_q <= 1'b0;
        end else if (done_q) begin
            to_cnt_q <= 16'h0000;
            to_arm_q <= 1'b1;
        end else if (to_p) begin
            to_arm_q <= 1'b0;
        end else if (tick && to_arm_q) begin
            to_cnt_q <= to_cnt_q + 16'h0001;
        end
    end

    // Pause and resume state of the transmitter
    always_ff @(posedge clk) begin
        if (!nrst || !inband_flow_enable) begin
            paused_q <= 1'b0;
        end else if (is_pau) begin
            paused_q <= 1'b1;
        end else if (is_res) begin
            paused_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    logic [3:0] tx_sub_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_idx_q;
    logic tx_par_q, tx_sidx_q;
    logic btick, can_go, tx_last_stop, take;

    assign btick = tick & (!ovs | (tx_sub_q == `ASC_OS_LAST));
    assign can_go = hold_v_q & !cts_n & !paused_q;
    assign tx_last_stop = !stop2 | tx_sidx_q;
    assign take = btick & can_go & ((tx_state_q == TX_IDLE) | ((tx_state_q == TX_STOP) & tx_last_stop));
    assign all_sent_irq_p = btick & (tx_state_q == TX_STOP) & tx_last_stop & !hold_v_q;

    // Transmit bit phase
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_sub_q <= 4'h0;
        end else if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
        end
    end

    // Holding register fed by software
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hold_q <= 8'h00;
            hold_v_q <= 1'b0;
        end else if (take) begin
            hold_v_q <= 1'b0;
        end else if (wr && paddr == `ASC_OFF_TXD && !hold_v_q) begin
            hold_q <= pwdata[7:0];
            hold_v_q <= 1'b1;
        end
    end

    // Transmit frame assembly
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_state_q <= TX_IDLE;
            tx_sh_q <= 8'h00;
            tx_idx_q <= 3'd0;
            tx_par_q <= 1'b0;
            tx_sidx_q <= 1'b0;
            line_q <= 1'b1;
        end else if (take) begin
            tx_state_q <= TX_START;
            tx_sh_q <= hold_q;
            tx_par_q <= asc_par_bit(hold_q, char_length_field, par_mode);
            tx_idx_q <= 3'd0;
            line_q <= 1'b0;
        end else if (btick) begin
            case (tx_state_q)
                TX_START, TX_DATA: begin
                    if (tx_state_q == TX_DATA && tx_idx_q == ({1'b0, char_length_field} + 3'd4)) begin
                        tx_state_q <= par_en ? TX_PAR : TX_STOP;
                        tx_sidx_q <= 1'b0;
                        line_q <= par_en ? tx_par_q : 1'b1;
                    end else begin
                        tx_idx_q <= tx_idx_q + ((tx_state_q == TX_DATA) ? 3'd1 : 3'd0);
                        tx_state_q <= TX_DATA;
                        line_q <= tx_sh_q[0];
                        tx_sh_q <= tx_sh_q >> 1;
                    end
                end
                TX_PAR: begin
                    tx_state_q <= TX_STOP;
                    line_q <= 1'b1;
                end
                TX_STOP: begin
                    tx_sidx_q <= 1'b1;
                    if (tx_last_stop) begin
                        tx_state_q <= TX_IDLE;
                    end
                end
                TX_IDLE: line_q <= 1'b1;
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // Line driver with break override
    always_ff @(posedge clk) begin
        if (!nrst) begin
            txd <= 1'b1;
        end else begin
            txd <= send_break_cmd ? 1'b0 : line_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_idle_line;
        tx_state_q == TX_IDLE && line_q;
    endsequence

    sequence s_start_seen;
        ovs && rx_state_q == RX_START && dec && bitv;
    endsequence

    a_brk_forces_low: assert property (send_break_cmd |=> !txd)
        else $error("break command did not hold line low");
    a_brk_release: assert property ($fell(send_break_cmd) |=> txd == $past(line_q))
        else $error("line not released after break");
    a_start_gated: assert property (take |-> !cts_n && !paused_q && hold_v_q)
        else $error("frame started while blocked");
    a_flow_off_resumed: assert property (!inband_flow_enable |=> !paused_q)
        else $error("flow disabled but paused");
    a_pause_takes: assert property (inband_flow_enable && is_pau |=> paused_q)
        else $error("pause character ignored");
    a_break_no_push: assert property (fin && is_brk |=> !done_q ##1 !q_wr)
        else $error("break character stored");
    a_discard_flow: assert property (done_q && discard_flow_chars && (is_res || is_pau) |-> !q_wr)
        else $error("flow character stored while discarding");
    a_all_sent_idle: assert property (all_sent_irq_p |=> s_idle_line)
        else $error("all sent without idle line");
    a_false_start: assert property (s_start_seen |=> rx_state_q == RX_IDLE)
        else $error("false start not abandoned");
    a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

endmodule : asc_channel

`default_nettype wire

// ==== rtl/asc_params.svh ====
// Register offsets, field positions, reset values and counts of the serial channel
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

// Register byte offsets
`define ASC_OFF_CTRL 8'h00
`define ASC_OFF_DIV 8'h04
`define ASC_OFF_FLOW 8'h08
`define ASC_OFF_RXCFG 8'h0c
`define ASC_OFF_EVT 8'h10
`define ASC_OFF_EVEN 8'h14
`define ASC_OFF_STAT 8'h18
`define ASC_OFF_RXD 8'h1c
`define ASC_OFF_TXD 8'h20

// Control register fields
`define ASC_C_RXEN 0
`define ASC_C_OVS 1
`define ASC_C_CHL 3:2
`define ASC_C_PAREN 4
`define ASC_C_PARM 6:5
`define ASC_C_STOP2 7
`define ASC_C_DPS 8
`define ASC_C_RX_FIFO_DATA_FORMAT 9
`define ASC_C_TERMINATION_DETECT_ENABLE 10
`define ASC_C_DXS 11
`define ASC_C_INBAND_FLOW_ENABLE 12
`define ASC_C_SEND_BREAK_CMD 13
`define ASC_C_TOEN 14

// Reset values
`define ASC_CTRL_RST 15'h0002
`define ASC_DIV_RST 16'h0000
`define ASC_FLOW_RST 32'h00001311
`define ASC_RXCFG_RST 32'h00000100
`define ASC_NEVT 11

// Oversampling points within a bit
`define ASC_OS_S0 4'h7
`define ASC_OS_S1 4'h8
`define ASC_OS_DEC 4'h9
`define ASC_OS_LAST 4'hf

`endif

// ==== rtl/asc_pkg.sv ====
// Types and shared helpers of the serial channel
package asc_pkg;

    typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE} asc_par_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} asc_rx_st_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asc_tx_st_t;

    // One receive queue entry
    typedef struct packed {
        logic pe;
        logic fe;
        logic par;
        logic [7:0] data;
    } asc_rxe_t;

    // Mask of the significant bits for a character length code
    function automatic logic [7:0] asc_len_mask(input logic [1:0] char_length_field);
        return 8'hff >> (2'd3 - char_length_field);
    endfunction : asc_len_mask

    // Parity bit for a character
    function automatic logic asc_par_bit(input logic [7:0] d, input logic [1:0] char_length_field, input asc_par_t m);
        logic p;
        p = ^(d & asc_len_mask(char_length_field));
        case (m)
            PAR_EVEN: return p;
            PAR_ODD: return ~p;
            PAR_MARK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : asc_par_bit

    // Masked compare over the character length
    function automatic logic asc_match(input logic [7:0] d, input logic [7:0] v, input logic [7:0] m,
                                       input logic [1:0] char_length_field);
        return ((d ^ v) & ~m & asc_len_mask(char_length_field)) == 8'h00;
    endfunction : asc_match

endpackage : asc_pkg

// ==== rtl/asc_rxq_mem.sv ====
// Receive queue storage with registered read data
`timescale 1ns/1ns
`default_nettype none

module asc_rxq_mem #(
    parameter int W = 11,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);

    logic [W-1:0] mem [DEPTH];

    // Write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule : asc_rxq_mem

`default_nettype wire
